// ### pwmeg_top.sv
/*
 * Pwm edge mode generator: period counter, per-mode edge targets and the
 * output, trigger and blanking channels.
 * Assumes all inputs are synchronous to clk and hold steady config values.
 */
// Summary of operation
// - Phase trigger from register or filter duty.
// - Multi mode: two phases, both from filter duty.
// - Multi mode ignores events two and four.
// - Multi: B may wrap, A clamped.
// - Multi: cycle adjust B added to B.
// - Resonant: average of two dead times.
// - Resonant A: e1 to duty minus average.
// - Resonant B edges from dead time, period.
// - Resonant adaptive triggers after duty, half duty.
// - Triangular: only output B generated.
// - Triangular B centred on half period.
// - Leading: A falls e1, rises earlier.
// - Leading adaptive triggers before event one.
// - Leading B: rise e4, fall at A rise plus e3 minus e2.
// - Sample triggers, blanking straight from inputs.
// - Counter runs zero to period limit.
// - Signals change the cycle after counter hits target.
`timescale 1ns/10ps
`include "pwmeg_defs.svh"

module pwmeg_top #(
    parameter int W = `PWMEG_CNT_W
) (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Configuration.
    input  wire pwmeg_pkg::pwmeg_mode_e mode_sel,
    input  wire logic                 phase_from_filter,
    input  wire logic [W-1:0]         period_limit,
    input  wire logic [W-1:0]         phase_trig_value,
    // Event values.
    input  wire logic [W-1:0]         event1,
    input  wire logic [W-1:0]         event2,
    input  wire logic [W-1:0]         event3,
    input  wire logic [W-1:0]         event4,
    // Signed adjusts and adaptive offset.
    input  wire logic [W-1:0]         cyc_adj_a,
    input  wire logic [W-1:0]         cyc_adj_b,
    input  wire logic [W-1:0]         adapt_ofs,
    // Control filter outputs.
    input  wire logic [W-1:0]         filt_duty,
    input  wire logic [W-1:0]         filt_period,
    // Fixed trigger and blanking points.
    input  wire logic [W-1:0]         sample1_at,
    input  wire logic [W-1:0]         sample2_at,
    input  wire logic [W-1:0]         blank_a_begin,
    input  wire logic [W-1:0]         blank_a_end,
    input  wire logic [W-1:0]         blank_b_begin,
    input  wire logic [W-1:0]         blank_b_end,
    // Gate drive outputs.
    output logic                      pwm_out_a,
    output logic                      pwm_out_b,
    // Trigger and blanking outputs.
    output logic                      adapt_trig_a,
    output logic                      adapt_trig_b,
    output logic                      sample_trig_1,
    output logic                      sample_trig_2,
    output logic                      blank_a,
    output logic                      blank_b,
    output logic                      phase_trig
);
    import pwmeg_pkg::*;

    localparam int EW = W + `PWMEG_GUARD_W;
    typedef logic signed [EW-1:0] pwmeg_wide_t;

    typedef struct packed {
        logic [W-1:0] cnt;
        pwmeg_mode_e  mode;
        logic [W-1:0] a_on;
        logic [W-1:0] a_off;
        logic [W-1:0] b_on;
        logic [W-1:0] b_off;
        logic [W-1:0] ta;
        logic [W-1:0] tb;
        logic [W-1:0] ph;
        logic         a_en;
        logic         b_on_en;
        logic         b_off_en;
        logic         t_en;
    } pwmeg_state_s;

    pwmeg_state_s st_reg;
    pwmeg_state_s st_next;

    // Widens an unsigned value.
    function automatic pwmeg_wide_t ux(input logic [W-1:0] v);
        return pwmeg_wide_t'({{`PWMEG_GUARD_W{1'b0}}, v});
    endfunction

    // Widens a two's complement value.
    function automatic pwmeg_wide_t sx(input logic [W-1:0] v);
        return pwmeg_wide_t'({{`PWMEG_GUARD_W{v[W-1]}}, v});
    endfunction

    // Limits a target into the period so it never crosses the boundary.
    function automatic logic [W-1:0] clampp(input pwmeg_wide_t x,
                                            input logic [W-1:0] lim);
        logic [W-1:0] r;
        r = x[W-1:0];
        if (x < 0) begin
            r = '0;
        end else if (x > ux(lim)) begin
            r = lim;
        end
        return r;
    endfunction

    // Folds a target that runs past the period into the next period.
    function automatic logic [W-1:0] wrapp(input pwmeg_wide_t x,
                                           input logic [W-1:0] lim);
        pwmeg_wide_t r;
        r = x;
        if (x < 0) begin
            r = x + ux(lim) + pwmeg_wide_t'(1);
        end else if (x > ux(lim)) begin
            r = x - ux(lim) - pwmeg_wide_t'(1);
        end
        return r[W-1:0];
    endfunction

    // Shared edge terms.
    pwmeg_wide_t e1_w;
    pwmeg_wide_t duty_w;
    pwmeg_wide_t half_duty_w;
    pwmeg_wide_t half_prd_w;
    pwmeg_wide_t adj_a_w;
    pwmeg_wide_t adj_b_w;
    pwmeg_wide_t ofs_w;
    pwmeg_wide_t dt1_w;
    pwmeg_wide_t dt2_w;
    pwmeg_wide_t avg_dt_w;
    pwmeg_wide_t width_b_w;
    logic        wrap_now;

    assign e1_w        = ux(event1);
    assign duty_w      = ux(filt_duty);
    assign half_duty_w = ux(filt_duty) >>> 1;
    assign half_prd_w  = ux(period_limit) >>> 1;
    assign adj_a_w     = sx(cyc_adj_a);
    assign adj_b_w     = sx(cyc_adj_b);
    assign ofs_w       = sx(adapt_ofs);
    assign width_b_w   = duty_w + adj_b_w;
    assign dt1_w    = ux(event3) - ux(event2);
    assign dt2_w    = e1_w + ux(period_limit) - ux(event4);
    assign avg_dt_w = (dt1_w + dt2_w) >>> 1;
    assign wrap_now = (st_reg.cnt >= period_limit);

    // Counter step and, at the period end, the next period's targets.
    always_comb begin
        st_next = st_reg;
        st_next.cnt = wrap_now ? '0 : st_reg.cnt + 1'b1;
        if (wrap_now) begin
            st_next.mode     = mode_sel;
            st_next.a_en     = 1'b1;
            st_next.b_on_en  = 1'b1;
            st_next.b_off_en = 1'b1;
            st_next.t_en     = 1'b1;
            st_next.ph = phase_from_filter ? filt_duty : phase_trig_value;
            // Normal placement; other modes override below.
            st_next.a_on  = event1;
            st_next.a_off = clampp(e1_w + duty_w + adj_a_w, period_limit);
            st_next.ta    = clampp(e1_w + duty_w + ofs_w, period_limit);
            st_next.tb    = clampp(e1_w + half_duty_w + ofs_w, period_limit);
            st_next.b_on  = clampp(e1_w + duty_w + adj_a_w + ux(event3)
                                   - ux(event2), period_limit);
            st_next.b_off = event4;
            case (mode_sel)
                PWMEG_MULTI: begin
                    st_next.b_on = event3;
                    st_next.b_off    = wrapp(ux(event3) + width_b_w, period_limit);
                    st_next.b_on_en  = (width_b_w > 0);
                    st_next.b_off_en = (width_b_w <= ux(period_limit));
                end
                PWMEG_RESONANT: begin
                    st_next.a_off = clampp(e1_w + duty_w - avg_dt_w, period_limit);
                    st_next.b_on  = clampp(e1_w + duty_w - avg_dt_w + dt1_w,
                                           period_limit);
                    st_next.b_off = clampp(ux(filt_period) - ux(period_limit)
                                           + ux(event4), period_limit);
                    st_next.ta = clampp(e1_w + duty_w + ofs_w, period_limit);
                    st_next.tb = clampp(e1_w + half_duty_w + ofs_w, period_limit);
                end
                PWMEG_TRIANGULAR: begin
                    st_next.a_en = 1'b0;
                    st_next.t_en = 1'b0;
                    st_next.b_on  = clampp(half_prd_w - half_duty_w + adj_a_w,
                                           period_limit);
                    st_next.b_off = clampp(half_prd_w + half_duty_w + adj_b_w,
                                           period_limit);
                end
                PWMEG_LEADING: begin
                    st_next.a_off = event1;
                    st_next.a_on  = clampp(e1_w - duty_w + adj_a_w, period_limit);
                    st_next.ta = clampp(e1_w - duty_w + ofs_w, period_limit);
                    st_next.tb = clampp(e1_w - half_duty_w + ofs_w, period_limit);
                    st_next.b_on  = event4;
                    st_next.b_off = clampp(e1_w - duty_w + adj_a_w - ux(event2)
                                           + ux(event3), period_limit);
                end
                default: begin
                end
            endcase
        end
    end

    // State register; targets stay disabled until the first period ends.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg     <= '0;
            st_reg.cnt <= `PWMEG_CNT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    logic tri_kill;
    logic a_kill;
    assign tri_kill = (st_reg.mode == PWMEG_TRIANGULAR);
    // A ends before a multi period
    assign a_kill   = tri_kill || (wrap_now && mode_sel == PWMEG_MULTI);

    // Output A; held off in triangular mode.
    pwmeg_edge #(.W(W)) u_out_a (
        .clk(clk), .rst(rst), .cnt(st_reg.cnt),
        .on_at(st_reg.a_on), .off_at(st_reg.a_off),
        .on_en(st_reg.a_en), .off_en(st_reg.a_en), .kill(a_kill),
        .level(pwm_out_a), .pulse());

    // Output B.
    pwmeg_edge #(.W(W)) u_out_b (
        .clk(clk), .rst(rst), .cnt(st_reg.cnt),
        .on_at(st_reg.b_on), .off_at(st_reg.b_off),
        .on_en(st_reg.b_on_en), .off_en(st_reg.b_off_en), .kill(1'b0),
        .level(pwm_out_b), .pulse());

    // Adaptive sample triggers.
    pwmeg_edge #(.W(W)) u_trig_a (
        .clk(clk), .rst(rst), .cnt(st_reg.cnt),
        .on_at(st_reg.ta), .off_at(st_reg.ta),
        .on_en(st_reg.t_en), .off_en(1'b0), .kill(1'b0),
        .level(), .pulse(adapt_trig_a));
    pwmeg_edge #(.W(W)) u_trig_b (
        .clk(clk), .rst(rst), .cnt(st_reg.cnt),
        .on_at(st_reg.tb), .off_at(st_reg.tb),
        .on_en(st_reg.t_en), .off_en(1'b0), .kill(1'b0),
        .level(), .pulse(adapt_trig_b));

    // Phase trigger to other generators.
    pwmeg_edge #(.W(W)) u_phase (
        .clk(clk), .rst(rst), .cnt(st_reg.cnt),
        .on_at(st_reg.ph), .off_at(st_reg.ph),
        .on_en(st_reg.a_en | st_reg.t_en | st_reg.b_on_en), .off_en(1'b0),
        .kill(1'b0), .level(), .pulse(phase_trig));

    pwmeg_edge #(.W(W)) u_samp_1 (
        .clk(clk), .rst(rst), .cnt(st_reg.cnt),
        .on_at(sample1_at), .off_at(sample1_at),
        .on_en(1'b1), .off_en(1'b0), .kill(1'b0),
        .level(), .pulse(sample_trig_1));
    pwmeg_edge #(.W(W)) u_samp_2 (
        .clk(clk), .rst(rst), .cnt(st_reg.cnt),
        .on_at(sample2_at), .off_at(sample2_at),
        .on_en(1'b1), .off_en(1'b0), .kill(1'b0),
        .level(), .pulse(sample_trig_2));
    pwmeg_edge #(.W(W)) u_blank_a (
        .clk(clk), .rst(rst), .cnt(st_reg.cnt),
        .on_at(blank_a_begin), .off_at(blank_a_end),
        .on_en(1'b1), .off_en(1'b1), .kill(1'b0),
        .level(blank_a), .pulse());
    pwmeg_edge #(.W(W)) u_blank_b (
        .clk(clk), .rst(rst), .cnt(st_reg.cnt),
        .on_at(blank_b_begin), .off_at(blank_b_end),
        .on_en(1'b1), .off_en(1'b1), .kill(1'b0),
        .level(blank_b), .pulse());

    // Period end followed by a restart from zero.
    sequence s_period_end;
        st_reg.cnt >= period_limit;
    endsequence
    sequence s_restart;
        st_reg.cnt == '0;
    endsequence

    a_cnt_wrap: assert property (@(posedge clk) disable iff (rst)
        s_period_end |=> s_restart)
        else $error("counter did not return to zero");
    a_cnt_step: assert property (@(posedge clk) disable iff (rst)
        (st_reg.cnt < period_limit) |=> (st_reg.cnt == $past(st_reg.cnt) + 1'b1))
        else $error("counter did not step by one");
    a_targets_hold: assert property (@(posedge clk) disable iff (rst)
        !wrap_now |=> $stable(st_reg.a_off) && $stable(st_reg.b_off))
        else $error("targets changed inside a period");
    a_phase_source: assert property (@(posedge clk) disable iff (rst)
        s_period_end |=> (st_reg.ph == ($past(phase_from_filter) ? $past(filt_duty)
                                        : $past(phase_trig_value))))
        else $error("phase target from wrong source");
    a_tri_no_a: assert property (@(posedge clk) disable iff (rst)
        (tri_kill && $past(tri_kill)) |-> (!pwm_out_a && !adapt_trig_a))
        else $error("output A active in triangular mode");
    a_sample_direct: assert property (@(posedge clk) disable iff (rst)
        (st_reg.cnt == sample1_at) |=> sample_trig_1)
        else $error("sample trigger 1 missed its point");
    a_lead_a_fall: assert property (@(posedge clk) disable iff (rst)
        (s_period_end and (mode_sel == PWMEG_LEADING)) |=> (st_reg.a_off == $past(event1)))
        else $error("leading A fall not at event one");
    a_multi_b_rise: assert property (@(posedge clk) disable iff (rst)
        (s_period_end and (mode_sel == PWMEG_MULTI)) |=> (st_reg.b_on == $past(event3)))
        else $error("multi B rise not at event three");
    a_a_in_period: assert property (@(posedge clk) disable iff (rst)
        (st_reg.cnt == '0 && st_reg.mode == PWMEG_MULTI) |-> !pwm_out_a)
        else $error("output A crossed the period boundary");
endmodule

// ### pwmeg_defs.svh
/*
 * Constants for the pwm edge mode generator: widths and reset values.
 * Assumes it is included by its bare name before any module that uses it.
 */
`ifndef PWMEG_DEFS_SVH
`define PWMEG_DEFS_SVH

// Default width of the period counter and of every edge target.
`define PWMEG_CNT_W 16
// Extra headroom bits used while edge sums are worked out.
`define PWMEG_GUARD_W 3
// Reset value of the period counter.
`define PWMEG_CNT_RST 16'h0000

`endif

// ### pwmeg_pkg.sv
/*
 * Types shared by the pwm edge mode generator.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pwmeg_pkg;

    // Edge placement modes of the generator.
    typedef enum logic [2:0] {
        PWMEG_NORMAL,
        PWMEG_MULTI,
        PWMEG_RESONANT,
        PWMEG_TRIANGULAR,
        PWMEG_LEADING
    } pwmeg_mode_e;

endpackage

// ### pwmeg_edge.sv
/*
 * One edge channel: a level that is set and cleared on counter matches,
 * plus a one-cycle pulse on the set match.
 * Assumes the counter and targets are synchronous to clk.
 */
`timescale 1ns/10ps
`include "pwmeg_defs.svh"

module pwmeg_edge #(
    parameter int W = `PWMEG_CNT_W
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst,
    // Counter and targets.
    input  wire logic [W-1:0] cnt,
    input  wire logic [W-1:0] on_at,
    input  wire logic [W-1:0] off_at,
    input  wire logic         on_en,
    input  wire logic         off_en,
    input  wire logic         kill,
    // Outputs.
    output logic              level,
    output logic              pulse
);
    typedef struct packed {
        logic level;
        logic pulse;
    } pwmeg_edge_s;

    pwmeg_edge_s st_reg;
    pwmeg_edge_s st_next;

    // change on match
    // Clear on the off match, set on the on match; the set wins a tie.
    always_comb begin
        st_next = st_reg;
        st_next.pulse = on_en && (cnt == on_at);
        if (kill || (off_en && (cnt == off_at))) begin
            st_next.level = 1'b0;
        end
        if (!kill && on_en && (cnt == on_at)) begin
            st_next.level = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.level;
    assign pulse = st_reg.pulse;

    // A set match raises the level on the next edge unless killed.
    a_set_match: assert property (@(posedge clk) disable iff (rst)
        (on_en && !kill && cnt == on_at) |=> (level && pulse))
        else $error("edge set match did not raise level");
endmodule

// ### pwmeg_far_side.sv
/*
 * Far side model: two gate drivers that count the turn-on edges they receive.
 * Assumes the gate levels are synchronous to clk and reset is asynchronous.
 */
`timescale 1ns/10ps

module pwmeg_far_side (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Gate drive levels.
    input  wire logic        gate_a,
    input  wire logic        gate_b,
    // Turn-on counts.
    output logic      [15:0] on_cnt_a,
    output logic      [15:0] on_cnt_b
);
    logic gate_a_reg;
    logic gate_b_reg;

    // A driver sees a turn-on where its level was low one cycle earlier.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_cnt_a   <= 16'h0000;
            on_cnt_b   <= 16'h0000;
            gate_a_reg <= 1'b0;
            gate_b_reg <= 1'b0;
        end else begin
            if (gate_a && !gate_a_reg) begin
                on_cnt_a <= on_cnt_a + 16'h0001;
            end
            if (gate_b && !gate_b_reg) begin
                on_cnt_b <= on_cnt_b + 16'h0001;
            end
            gate_a_reg <= gate_a;
            gate_b_reg <= gate_b;
        end
    end
endmodule

// ### test_pwm_edge_mode_generator.sv
/*
 * Self-checking bench: a cycle model of the edge generator compared each cycle.
 * Assumes the design package and header are compiled first.
 */
`timescale 1ns/10ps

module test_pwm_edge_mode_generator;
    import pwmeg_pkg::*;
    localparam int W = 16;
    logic clk = 1'b0;
    logic rst, phase_from_filter;
    pwmeg_mode_e mode_sel;
    logic [W-1:0] period_limit, phase_trig_value, event1, event2, event3, event4;
    logic [W-1:0] cyc_adj_a, cyc_adj_b, adapt_ofs, filt_duty, filt_period;
    logic [W-1:0] sample1_at, sample2_at, blank_a_begin, blank_a_end, blank_b_begin, blank_b_end;
    logic pwm_out_a, pwm_out_b, adapt_trig_a, adapt_trig_b;
    logic sample_trig_1, sample_trig_2, blank_a, blank_b, phase_trig;
    logic [15:0] pca, pcb;
    int n_mismatch = 0;
    int checked = 0;
    int cnt, a_on, a_off, b_on, b_off, ta_at, tb_at, ph_at, ea, eb, ea_old, eb_old;
    bit en, tri_m, ra, rb, wrap_t;
    logic ma, mb, mta, mtb, m1, m2, mba, mbb, mph;

    pwmeg_top #(.W(W)) pwmeg_top_i (.clk, .rst, .mode_sel, .phase_from_filter, .period_limit,
        .phase_trig_value, .event1, .event2, .event3, .event4, .cyc_adj_a, .cyc_adj_b,
        .adapt_ofs, .filt_duty, .filt_period, .sample1_at, .sample2_at, .blank_a_begin,
        .blank_a_end, .blank_b_begin, .blank_b_end, .pwm_out_a, .pwm_out_b, .adapt_trig_a,
        .adapt_trig_b, .sample_trig_1, .sample_trig_2, .blank_a, .blank_b, .phase_trig);

    pwmeg_far_side pwmeg_far_side_i (.clk(clk), .rst(rst), .gate_a(pwm_out_a),
        .gate_b(pwm_out_b), .on_cnt_a(pca), .on_cnt_b(pcb));

    // Clock at 200 MHz.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Compares one value and counts the result.
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // mode targets
    // Stimulus keeps every target inside the period, so no clamping is modelled.
    task automatic latch;
        int d, aa, ab, o, avg;
        d = filt_duty;
        aa = $signed(cyc_adj_a);
        ab = $signed(cyc_adj_b);
        o = $signed(adapt_ofs);
        tri_m = (mode_sel == PWMEG_TRIANGULAR);
        a_on = event1;
        a_off = event1 + d + aa;
        b_on = a_off + event3 - event2;
        b_off = event4;
        ta_at = event1 + d + o;
        tb_at = event1 + d / 2 + o;
        ph_at = phase_from_filter ? d : int'(phase_trig_value);
        case (mode_sel)
            PWMEG_MULTI: begin
                b_on = event3;
                b_off = (event3 + d + ab) % (period_limit + 1);
            end
            PWMEG_RESONANT: begin
                avg = ((event3 - event2) + (event1 + period_limit - event4)) / 2;
                a_off = event1 + d - avg;
                b_on = a_off + event3 - event2;
                b_off = filt_period - (period_limit - event4);
            end
            PWMEG_TRIANGULAR: begin
                b_on = period_limit / 2 - d / 2 + aa;
                b_off = period_limit / 2 + d / 2 + ab;
            end
            PWMEG_LEADING: begin
                a_on = event1 - d + aa;
                a_off = event1;
                ta_at = event1 - d + o;
                tb_at = event1 - d / 2 + o;
                b_on = event4;
                b_off = a_on - (event2 - event3);
            end
            default: begin
            end
        endcase
    endtask

    // counter and matches
    // Outputs follow the cycle in which the counter meets the target; set beats clear.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt = 0;
            en = 1'b0;
            tri_m = 1'b0;
            ea = 0;
            eb = 0;
            {ma, mb, mta, mtb, m1, m2, mba, mbb, mph} = '0;
        end else begin
            ra = ma;
            rb = mb;
            m1 = (cnt == sample1_at);
            m2 = (cnt == sample2_at);
            mba = (cnt == blank_a_begin) || (cnt != blank_a_end && mba);
            mbb = (cnt == blank_b_begin) || (cnt != blank_b_end && mbb);
            // A never runs on into a multi period.
            ma = en && !tri_m && !(cnt >= period_limit && mode_sel == PWMEG_MULTI)
                && ((cnt == a_on) || (cnt != a_off && ma));
            mb = en && ((cnt == b_on) || (cnt != b_off && mb));
            mta = en && !tri_m && cnt == ta_at;
            mtb = en && !tri_m && cnt == tb_at;
            mph = en && cnt == ph_at;
            ea += int'(ma && !ra);
            eb += int'(mb && !rb);
            if (cnt >= period_limit) begin
                latch();
                en = 1'b1;
                cnt = 0;
            end else begin
                cnt++;
            end
        end
    end

    // Every output is compared once a cycle, away from the launching edge.
    always @(negedge clk) begin
        chk("pwm_out_a", 16'(pwm_out_a), 16'(ma));
        chk("pwm_out_b", 16'(pwm_out_b), 16'(mb));
        chk("adapt_trig_a", 16'(adapt_trig_a), 16'(mta));
        chk("adapt_trig_b", 16'(adapt_trig_b), 16'(mtb));
        chk("sample_trig_1", 16'(sample_trig_1), 16'(m1));
        chk("sample_trig_2", 16'(sample_trig_2), 16'(m2));
        chk("blank_a", 16'(blank_a), 16'(mba));
        chk("blank_b", 16'(blank_b), 16'(mbb));
        chk("phase_trig", 16'(phase_trig), 16'(mph));
        if (!rst) begin
            chk("turn-ons a", pca, 16'(ea_old));
            chk("turn-ons b", pcb, 16'(eb_old));
        end
        ea_old = ea;
        eb_old = eb;
    end

    // New random settings, some of which land in mid-period and must wait.
    task automatic shuffle;
        int x, d;
        x = $urandom_range(0, 3);
        d = $urandom_range(4, 12);
        // the wrap phase keeps multi mode with a late B rise.
        mode_sel <= wrap_t ? PWMEG_MULTI : pwmeg_mode_e'($urandom_range(0, 4));
        phase_from_filter <= 1'($urandom_range(0, 1));
        phase_trig_value <= W'($urandom_range(0, period_limit));
        event1 <= W'($urandom_range(18, 22));
        event2 <= W'(x);
        event3 <= W'(wrap_t ? period_limit - $urandom_range(0, 6) : x + $urandom_range(2, 4));
        event4 <= W'(period_limit - $urandom_range(2, 5));
        filt_duty <= W'(d);
        filt_period <= W'(2 * d);
        cyc_adj_a <= W'($urandom_range(0, 4) - 2);
        cyc_adj_b <= W'($urandom_range(0, 4) - 2);
        adapt_ofs <= W'($urandom_range(0, 4) - 2);
        sample1_at <= W'($urandom_range(0, period_limit));
        sample2_at <= W'($urandom_range(0, period_limit));
        blank_a_begin <= W'($urandom_range(0, period_limit));
        blank_a_end <= W'($urandom_range(0, period_limit));
        blank_b_begin <= W'($urandom_range(0, period_limit));
        blank_b_end <= W'($urandom_range(0, period_limit));
    endtask

    task automatic run(input int n);
        repeat (n) begin
            @(posedge clk);
            if ($urandom_range(0, 12) == 0) begin
                shuffle();
            end
        end
    endtask

    // Main sequence: random modes, then a reset in mid-run and more traffic.
    initial begin
        void'($urandom(32'h90a1_445a));
        rst = 1'b1;
        period_limit = W'($urandom_range(40, 60));
        shuffle();
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        run(4000);
        $display("Test random modes done");
        wrap_t = 1'b1;
        run(800);
        wrap_t = 1'b0;
        $display("Test multi wrap done");
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        run(2000);
        $display("Test second reset done");
        stop_test();
    end

    // Cuts a hang short.
    initial begin
        #(5 * 8000);
        n_mismatch++;
        stop_test();
    end
endmodule
